// ### ifb_consts.vh
// Register offsets, field positions and reset values of the flag bank
`ifndef IFB_CONSTS_VH
`define IFB_CONSTS_VH

// ==================================================================
// Register offsets on the plain register port
`define IFB_ADDR_W 4
`define IFB_OFS_FLAG_STATUS_SECOND 4'h0
`define IFB_OFS_ENABLE_CONTROL_FIRST 4'h1
`define IFB_OFS_IRQ_STATUS 4'h2
`define IFB_OFS_IRQ_MASK 4'h3

// ==================================================================
// Widths
`define IFB_DATA_W 16
`define IFB_FLAG_W 7
`define IFB_EN_W 15

// ==================================================================
// Reset values
`define IFB_RST_FLAG_STATUS_SECOND 16'h0000
`define IFB_RST_ENABLE_CONTROL_FIRST 16'h0000
`define IFB_RST_IRQ_MASK 16'h0000

// ==================================================================
// Fields of flag_status_second
`define IFB_BIT_CAPTURE4_REQ_FLAG 6
`define IFB_BIT_CAPTURE3_REQ_FLAG 5
`define IFB_BIT_DMA_CH3_DONE_FLAG 4
`define IFB_BIT_CAN_EVENT_FLAG 3
`define IFB_BIT_CAN_RX_FLAG 2
`define IFB_BIT_SPI_B_EVENT_FLAG 1
`define IFB_BIT_SPI_B_ERROR_FLAG 0

// ==================================================================
// Fields of enable_control_first
`define IFB_BIT_DMA_CH1_DONE_EN 14
`define IFB_BIT_ADC_DONE_EN 13
`define IFB_BIT_UART_A_TX_EN 12
`define IFB_BIT_UART_A_RX_EN 11
`define IFB_BIT_SPI_A_EVENT_EN 10
`define IFB_BIT_SPI_A_ERROR_EN 9
`define IFB_BIT_TIMER_C_EN 8
`define IFB_BIT_TIMER_B_EN 7
`define IFB_BIT_COMPARE_B_EN 6
`define IFB_BIT_CAPTURE_B_EN 5
`define IFB_BIT_DMA_CH0_DONE_EN 4
`define IFB_BIT_TIMER_A_EN 3
`define IFB_BIT_COMPARE_A_EN 2
`define IFB_BIT_CAPTURE_A_EN 1
`define IFB_BIT_EXT_IRQ_A_EN 0

`endif

// ### ifb_flag_cell.v
// Sticky flag register whose hardware set wins over a software load
`default_nettype none

module ifb_flag_cell #(
   parameter WIDTH = 7
) (
   input wire core_clk_in,
   input wire rst_in,
   input wire [WIDTH-1:0] set_in,
   input wire load_in,
   input wire [WIDTH-1:0] load_val_in,
   output reg [WIDTH-1:0] flag_out
);

   // ===============================================================
   // Flag storage
   // A set arriving with a load is OR-ed in after it, so no event is
   // ever lost to a write or a clearing read in the same cycle.
   always @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flag_out <= {WIDTH{1'b0}};
      end else begin
         flag_out <= (load_in ? load_val_in : flag_out) | set_in;
      end
   end

endmodule // ifb_flag_cell

`default_nettype wire

// ### ifb_gate.v
// Registered AND of a request vector with an enable vector
`default_nettype none

module ifb_gate #(
   parameter WIDTH = 15
) (
   input wire core_clk_in,
   input wire rst_in,
   input wire [WIDTH-1:0] req_in,
   input wire [WIDTH-1:0] en_in,
   output reg [WIDTH-1:0] gated_out
);

   // ===============================================================
   // Gating register
   always @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         gated_out <= {WIDTH{1'b0}};
      end else begin
         gated_out <= req_in & en_in;
      end
   end

endmodule // ifb_gate

`default_nettype wire

// ### ifb_src_model.sv
// Behavioural request sources on the far side of the flag bank
`default_nettype none
module ifb_src_model (
   input wire logic clk_in,
   input wire logic [6:0] fire_in,
   input wire logic [14:0] lvl_in,
   output logic [6:0] flag_src_out = 7'h00,
   output logic [14:0] first_src_out = 15'h0000
);
   timeunit 1ns;
   timeprecision 1ps;
   // Sources request whatever fire_in and lvl_in say, one clock later
   always @(posedge clk_in) begin
      flag_src_out <= fire_in;
      first_src_out <= lvl_in;
   end
endmodule // ifb_src_model
`default_nettype wire

// ### ifb_top.v
// Interrupt request flag and enable bank with register port and irq
//
// Function
// R1 - Capture 4 flag bit 6, capture 3 bit 5
// R2 - DMA3, CAN, CAN rx, SPI-B flags; 15:7 zero
// R3 - Flags show pending requests, RW, reset zero
// R4 - Without CAN, CAN flags never interrupt
// R5 - Upper enable byte bits 14..8; 15 zero
// R6 - Lower enable byte bits 7..0 as listed
// R7 - Enable passes request; flags sticky until written
`include "ifb_consts.vh"
`default_nettype none

module ifb_top #(
   parameter HAS_CAN = 1
) (
   input wire core_clk_in,
   input wire rst_in,
   input wire [`IFB_ADDR_W-1:0] reg_addr_in,
   input wire [`IFB_DATA_W-1:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [`IFB_DATA_W-1:0] reg_rdata_out,
   input wire [`IFB_FLAG_W-1:0] flag_src_in,
   input wire [`IFB_EN_W-1:0] first_src_flag_in,
   output wire [`IFB_FLAG_W-1:0] flag_pend_out,
   output wire [`IFB_EN_W-1:0] first_req_out,
   output reg [`IFB_EN_W-1:0] enable_out,
   output reg irq_out
);

   // ===============================================================
   // Reset values cut to the widths that are built
   // The shared constants are full words; slicing them here keeps
   // each reset assignment exactly as wide as its register.
   localparam [`IFB_DATA_W-1:0] EN_RST = `IFB_RST_ENABLE_CONTROL_FIRST;
   localparam [`IFB_DATA_W-1:0] MASK_RST = `IFB_RST_IRQ_MASK;

   // Write data under a short name for the per-field loads
   wire [`IFB_DATA_W-1:0] wd;
   assign wd = reg_wdata_in;

   // Software image of flag_status_second, one field at a time
   // A one written to a flag sets it, a zero clears it.
   wire [`IFB_FLAG_W-1:0] flag_wv;
   assign flag_wv[`IFB_BIT_CAPTURE4_REQ_FLAG] = wd[`IFB_BIT_CAPTURE4_REQ_FLAG];
   assign flag_wv[`IFB_BIT_CAPTURE3_REQ_FLAG] = wd[`IFB_BIT_CAPTURE3_REQ_FLAG];
   assign flag_wv[`IFB_BIT_DMA_CH3_DONE_FLAG] = wd[`IFB_BIT_DMA_CH3_DONE_FLAG];
   assign flag_wv[`IFB_BIT_CAN_EVENT_FLAG] = wd[`IFB_BIT_CAN_EVENT_FLAG];
   assign flag_wv[`IFB_BIT_CAN_RX_FLAG] = wd[`IFB_BIT_CAN_RX_FLAG];
   assign flag_wv[`IFB_BIT_SPI_B_EVENT_FLAG] = wd[`IFB_BIT_SPI_B_EVENT_FLAG];
   assign flag_wv[`IFB_BIT_SPI_B_ERROR_FLAG] = wd[`IFB_BIT_SPI_B_ERROR_FLAG];

   // ===============================================================
   // Address decode
   wire sel_flag;
   wire sel_en;
   wire sel_stat;
   wire sel_mask;
   assign sel_flag = (reg_addr_in == `IFB_OFS_FLAG_STATUS_SECOND);
   assign sel_en = (reg_addr_in == `IFB_OFS_ENABLE_CONTROL_FIRST);
   assign sel_stat = (reg_addr_in == `IFB_OFS_IRQ_STATUS);
   assign sel_mask = (reg_addr_in == `IFB_OFS_IRQ_MASK);

   wire wr_flag;
   wire wr_en;
   wire wr_mask;
   wire rd_stat;
   assign wr_flag = reg_wr_in & sel_flag;
   assign wr_en = reg_wr_in & sel_en;
   assign wr_mask = reg_wr_in & sel_mask;
   assign rd_stat = reg_rd_in & sel_stat;

   // ===============================================================
   // CAN variant gating
   // A part without the CAN controller keeps the flag bits writable
   // but they can never reach the priority logic or the irq.
   wire [`IFB_FLAG_W-1:0] can_keep;
   assign can_keep[`IFB_BIT_CAPTURE4_REQ_FLAG] = 1'b1;
   assign can_keep[`IFB_BIT_CAPTURE3_REQ_FLAG] = 1'b1;
   assign can_keep[`IFB_BIT_DMA_CH3_DONE_FLAG] = 1'b1;
   assign can_keep[`IFB_BIT_CAN_EVENT_FLAG] = (HAS_CAN != 0); // R4
   assign can_keep[`IFB_BIT_CAN_RX_FLAG] = (HAS_CAN != 0); // R4
   assign can_keep[`IFB_BIT_SPI_B_EVENT_FLAG] = 1'b1;
   assign can_keep[`IFB_BIT_SPI_B_ERROR_FLAG] = 1'b1;

   // ===============================================================
   // flag_status_second
   // Sources set flags regardless of any enable; only a software write
   // of zero clears them.
   wire [`IFB_FLAG_W-1:0] flag_q;
   ifb_flag_cell #(
      .WIDTH(`IFB_FLAG_W)
   ) u_flags (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .set_in(flag_src_in), // R1 R2 R7
      .load_in(wr_flag), // R3
      .load_val_in(flag_wv),
      .flag_out(flag_q)
   );

   // Pending requests towards the priority logic
   ifb_gate #(
      .WIDTH(`IFB_FLAG_W)
   ) u_pend (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .req_in(flag_q),
      .en_in(can_keep), // R4
      .gated_out(flag_pend_out)
   );

   // ===============================================================
   // enable_control_first
   reg [`IFB_EN_W-1:0] en_r;
   reg [`IFB_EN_W-1:0] en_nxt;

   always @* begin
      en_nxt = en_r;
      if (wr_en) begin
         // Bit 15 is never stored; a write to it vanishes
         en_nxt[`IFB_BIT_DMA_CH1_DONE_EN] = wd[`IFB_BIT_DMA_CH1_DONE_EN]; // R5
         en_nxt[`IFB_BIT_ADC_DONE_EN] = wd[`IFB_BIT_ADC_DONE_EN]; // R5
         en_nxt[`IFB_BIT_UART_A_TX_EN] = wd[`IFB_BIT_UART_A_TX_EN]; // R5
         en_nxt[`IFB_BIT_UART_A_RX_EN] = wd[`IFB_BIT_UART_A_RX_EN]; // R5
         en_nxt[`IFB_BIT_SPI_A_EVENT_EN] = wd[`IFB_BIT_SPI_A_EVENT_EN]; // R5
         en_nxt[`IFB_BIT_SPI_A_ERROR_EN] = wd[`IFB_BIT_SPI_A_ERROR_EN]; // R5
         en_nxt[`IFB_BIT_TIMER_C_EN] = wd[`IFB_BIT_TIMER_C_EN]; // R5
         en_nxt[`IFB_BIT_TIMER_B_EN] = wd[`IFB_BIT_TIMER_B_EN]; // R6
         en_nxt[`IFB_BIT_COMPARE_B_EN] = wd[`IFB_BIT_COMPARE_B_EN]; // R6
         en_nxt[`IFB_BIT_CAPTURE_B_EN] = wd[`IFB_BIT_CAPTURE_B_EN]; // R6
         en_nxt[`IFB_BIT_DMA_CH0_DONE_EN] = wd[`IFB_BIT_DMA_CH0_DONE_EN]; // R6
         en_nxt[`IFB_BIT_TIMER_A_EN] = wd[`IFB_BIT_TIMER_A_EN]; // R6
         en_nxt[`IFB_BIT_COMPARE_A_EN] = wd[`IFB_BIT_COMPARE_A_EN]; // R6
         en_nxt[`IFB_BIT_CAPTURE_A_EN] = wd[`IFB_BIT_CAPTURE_A_EN]; // R6
         en_nxt[`IFB_BIT_EXT_IRQ_A_EN] = wd[`IFB_BIT_EXT_IRQ_A_EN]; // R6
      end
   end

   always @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         en_r <= EN_RST[`IFB_EN_W-1:0]; // R3
         enable_out <= EN_RST[`IFB_EN_W-1:0];
      end else begin
         en_r <= en_nxt;
         enable_out <= en_nxt;
      end
   end

   // An enable of one lets the source's request through, zero blocks it
   ifb_gate #(
      .WIDTH(`IFB_EN_W)
   ) u_first (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .req_in(first_src_flag_in),
      .en_in(en_r), // R7
      .gated_out(first_req_out)
   );

   // ===============================================================
   // Interrupt status, mask and output
   // Status is sticky and cleared by reading it; a source event in the
   // reading cycle survives into the next read.
   wire [`IFB_FLAG_W-1:0] stat_q;
   wire [`IFB_FLAG_W-1:0] stat_set;
   assign stat_set = flag_src_in & can_keep; // R4

   ifb_flag_cell #(
      .WIDTH(`IFB_FLAG_W)
   ) u_stat (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .set_in(stat_set),
      .load_in(rd_stat),
      .load_val_in({`IFB_FLAG_W{1'b0}}),
      .flag_out(stat_q)
   );

   reg [`IFB_FLAG_W-1:0] mask_r;
   reg [`IFB_FLAG_W-1:0] mask_nxt;
   reg irq_nxt;
   wire [`IFB_FLAG_W-1:0] irq_hit;

   // Only sources that are both pending and masked in count
   assign irq_hit = stat_q & mask_r;

   // Mask uses the flag layout; bits 15:7 of a write are dropped
   always @* begin
      mask_nxt = mask_r;
      if (wr_mask) begin
         mask_nxt = wd[`IFB_FLAG_W-1:0];
      end
   end

   always @* begin
      irq_nxt = |irq_hit;
   end

   always @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mask_r <= MASK_RST[`IFB_FLAG_W-1:0];
         irq_out <= 1'b0;
      end else begin
         mask_r <= mask_nxt;
         // Lags status by one cycle so that the output is a flip-flop
         irq_out <= irq_nxt; // R7
      end
   end

   // ===============================================================
   // Named fields of flag_status_second
   // Sources set these whether or not anything is enabled.
   wire capture4_req_flag;
   wire capture3_req_flag;
   wire dma_ch3_done_flag;
   wire can_event_flag;
   wire can_rx_flag;
   wire spi_b_event_flag;
   wire spi_b_error_flag;
   assign capture4_req_flag = flag_q[`IFB_BIT_CAPTURE4_REQ_FLAG]; // R1
   assign capture3_req_flag = flag_q[`IFB_BIT_CAPTURE3_REQ_FLAG]; // R1
   assign dma_ch3_done_flag = flag_q[`IFB_BIT_DMA_CH3_DONE_FLAG]; // R2
   assign can_event_flag = flag_q[`IFB_BIT_CAN_EVENT_FLAG]; // R2
   assign can_rx_flag = flag_q[`IFB_BIT_CAN_RX_FLAG]; // R2
   assign spi_b_event_flag = flag_q[`IFB_BIT_SPI_B_EVENT_FLAG]; // R2
   assign spi_b_error_flag = flag_q[`IFB_BIT_SPI_B_ERROR_FLAG]; // R2

   // Bits 15:7 are not built and always read zero
   wire [`IFB_DATA_W-1:0] flag_word;
   assign flag_word = {
      9'h000, // R2
      capture4_req_flag,
      capture3_req_flag,
      dma_ch3_done_flag,
      can_event_flag,
      can_rx_flag,
      spi_b_event_flag,
      spi_b_error_flag
   };

   // ===============================================================
   // Named fields of enable_control_first
   wire dma_ch1_done_en;
   wire adc_done_en;
   wire uart_a_tx_en;
   wire uart_a_rx_en;
   wire spi_a_event_en;
   wire spi_a_error_en;
   wire timer_c_en;
   wire timer_b_en;
   wire compare_b_en;
   wire capture_b_en;
   wire dma_ch0_done_en;
   wire timer_a_en;
   wire compare_a_en;
   wire capture_a_en;
   wire ext_irq_a_en;
   assign dma_ch1_done_en = en_r[`IFB_BIT_DMA_CH1_DONE_EN]; // R5
   assign adc_done_en = en_r[`IFB_BIT_ADC_DONE_EN]; // R5
   assign uart_a_tx_en = en_r[`IFB_BIT_UART_A_TX_EN]; // R5
   assign uart_a_rx_en = en_r[`IFB_BIT_UART_A_RX_EN]; // R5
   assign spi_a_event_en = en_r[`IFB_BIT_SPI_A_EVENT_EN]; // R5
   assign spi_a_error_en = en_r[`IFB_BIT_SPI_A_ERROR_EN]; // R5
   assign timer_c_en = en_r[`IFB_BIT_TIMER_C_EN]; // R5
   assign timer_b_en = en_r[`IFB_BIT_TIMER_B_EN]; // R6
   assign compare_b_en = en_r[`IFB_BIT_COMPARE_B_EN]; // R6
   assign capture_b_en = en_r[`IFB_BIT_CAPTURE_B_EN]; // R6
   assign dma_ch0_done_en = en_r[`IFB_BIT_DMA_CH0_DONE_EN]; // R6
   assign timer_a_en = en_r[`IFB_BIT_TIMER_A_EN]; // R6
   assign compare_a_en = en_r[`IFB_BIT_COMPARE_A_EN]; // R6
   assign capture_a_en = en_r[`IFB_BIT_CAPTURE_A_EN]; // R6
   assign ext_irq_a_en = en_r[`IFB_BIT_EXT_IRQ_A_EN]; // R6

   // Bit 15 has no enable behind it and reads zero
   wire [`IFB_DATA_W-1:0] en_word;
   assign en_word = {
      1'b0, // R5
      dma_ch1_done_en,
      adc_done_en,
      uart_a_tx_en,
      uart_a_rx_en,
      spi_a_event_en,
      spi_a_error_en,
      timer_c_en,
      timer_b_en,
      compare_b_en,
      capture_b_en,
      dma_ch0_done_en,
      timer_a_en,
      compare_a_en,
      capture_a_en,
      ext_irq_a_en
   };

   // ===============================================================
   // Status and mask words
   // Both use the flag layout, so their upper bits read zero too.
   wire [`IFB_DATA_W-1:0] stat_word;
   wire [`IFB_DATA_W-1:0] mask_word;
   assign stat_word = {9'h000, stat_q};
   assign mask_word = {9'h000, mask_r};

   // ===============================================================
   // Read data, one cycle after the strobe
   reg [`IFB_DATA_W-1:0] rdata_nxt;

   always @* begin
      rdata_nxt = {`IFB_DATA_W{1'b0}};
      case (reg_addr_in)
         `IFB_OFS_FLAG_STATUS_SECOND: begin
            rdata_nxt = flag_word; // R2 R3
         end
         `IFB_OFS_ENABLE_CONTROL_FIRST: begin
            rdata_nxt = en_word; // R5
         end
         `IFB_OFS_IRQ_STATUS: begin
            rdata_nxt = stat_word;
         end
         `IFB_OFS_IRQ_MASK: begin
            rdata_nxt = mask_word;
         end
         default: begin
            rdata_nxt = {`IFB_DATA_W{1'b0}};
         end
      endcase
   end

   always @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= {`IFB_DATA_W{1'b0}};
      end else if (reg_rd_in) begin
         reg_rdata_out <= rdata_nxt;
      end else begin
         reg_rdata_out <= {`IFB_DATA_W{1'b0}};
      end
   end

endmodule // ifb_top

`default_nettype wire

// ### ifb_top_checker.sv
// Concurrent checks on the flag bank ports
`default_nettype none
module ifb_top_checker #(parameter HAS_CAN = 1) (
   input wire core_clk_in,
   input wire rst_in,
   input wire [3:0] reg_addr_in,
   input wire [15:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [15:0] reg_rdata_out,
   input wire [6:0] flag_src_in,
   input wire [14:0] first_src_flag_in,
   input wire [6:0] flag_pend_out,
   input wire [14:0] first_req_out,
   input wire [14:0] enable_out,
   input wire irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [14:0] wd_en = reg_wdata_in[14:0];
   wire mask_wr = reg_wr_in && reg_addr_in == 4'h3;
   wire flag_clr = reg_wr_in && reg_addr_in == 4'h0 && !reg_wdata_in[5];
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   a_rdata_idle: assert property (
      !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000) else $error("stray rdata");
   a_rd_zero: assert property (reg_rd_in |=> !reg_rdata_out[15] &&
      ($past(reg_addr_in) == 4'h1 || reg_rdata_out[15:7] == 9'h000))
      else $error("unused bits set");
   a_en_write: assert property (
      reg_wr_in && reg_addr_in == 4'h1 |=> enable_out == $past(wd_en))
      else $error("enable not written");
   a_gate_req: assert property (
      first_req_out == ($past(first_src_flag_in) & $past(enable_out)))
      else $error("gated request wrong");
   a_src_pend: assert property (flag_src_in[6] |-> ##2 flag_pend_out[6])
      else $error("capture flag lost");
   a_no_can: assert property (
      HAS_CAN != 0 || flag_pend_out[3:2] == 2'b00) else $error("CAN pend");
   a_irq_rise: assert property ($rose(irq_out) |->
      $past(flag_src_in, 2) != 7'h00 || $past(mask_wr, 2))
      else $error("irq without cause");
   a_irq_clear: assert property (
      reg_rd_in && reg_addr_in == 4'h2 && flag_src_in == 7'h00 |-> ##2 !irq_out)
      else $error("irq kept after read");
   a_flag_sticky: assert property (
      $fell(flag_pend_out[5]) |-> $past(flag_clr, 2))
      else $error("flag dropped alone");
   cover property ($rose(irq_out));
   cover property (reg_rd_in && reg_addr_in == 4'h2);
   cover property (flag_pend_out[6]);
endmodule // ifb_top_checker
bind ifb_top ifb_top_checker #(.HAS_CAN(HAS_CAN)) u_chk (.core_clk_in,
   .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
   .reg_rdata_out, .flag_src_in, .first_src_flag_in, .flag_pend_out,
   .first_req_out, .enable_out, .irq_out);
`default_nettype wire

// ### ifb_top_test.sv
// Self-checking bench for the flag and enable bank
`default_nettype none
module ifb_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in = 0;
   logic rst_in = 1;
   logic [3:0] reg_addr_in = 0;
   logic [15:0] reg_wdata_in = 0;
   logic reg_wr_in = 0;
   logic reg_rd_in = 0;
   logic [6:0] fire_v = 0;
   logic [14:0] lvl_v = 0;
   wire [15:0] reg_rdata_out;
   wire [6:0] flag_src_in, flag_pend_out;
   wire [14:0] first_src_flag_in, first_req_out, enable_out;
   wire irq_out;
   wire [6:0] pend_nc;
   wire irq_nc;
   logic [15:0] exp_q[$];
   logic rd_seen = 0;
   int bad_count = 0;
   int samples_checked = 0;
   logic [15:0] d;
   logic [6:0] acc;
   always #12.5 core_clk_in = ~core_clk_in;
   ifb_top dut (.core_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
      .reg_wr_in, .reg_rd_in, .reg_rdata_out, .flag_src_in,
      .first_src_flag_in, .flag_pend_out, .first_req_out, .enable_out,
      .irq_out);
   // Same bank built without the CAN controller
   ifb_top #(.HAS_CAN(0)) dut_nc (.core_clk_in, .rst_in, .reg_addr_in,
      .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out(),
      .flag_src_in, .first_src_flag_in, .flag_pend_out(pend_nc),
      .first_req_out(), .enable_out(), .irq_out(irq_nc));
   ifb_src_model src (.clk_in(core_clk_in), .fire_in(fire_v),
      .lvl_in(lvl_v), .flag_src_out(flag_src_in),
      .first_src_out(first_src_flag_in));
   task automatic check(input string nm, input logic [15:0] s, e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge core_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= v;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] v);
      exp_q.push_back(v);
      @(posedge core_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
   endtask
   task automatic pulse(input logic [6:0] v);
      @(posedge core_clk_in);
      fire_v <= v;
      @(posedge core_clk_in);
      fire_v <= 7'h00;
      repeat (2) @(posedge core_clk_in);
      @(negedge core_clk_in);
   endtask
   // Read data stand only in the cycle after the strobe
   always @(negedge core_clk_in) begin
      if (rd_seen) check("rdata", reg_rdata_out, exp_q.pop_front());
      rd_seen = reg_rd_in;
   end
   // ==========
   // Main sequence
   initial begin
      d = $urandom(32'h3F2B1124);
      repeat (3) @(posedge core_clk_in);
      rst_in <= 1'b0;
      for (int i = 0; i < 5; i++) rd(i == 4 ? 4'h9 : 4'(i), 16'h0000);
      $display("reset values done");
      for (int i = 0; i < 3; i++) begin
         d = (i == 0) ? 16'hFFFF : 16'($urandom);
         wr(4'h1, d);
         rd(4'h1, d & 16'h7FFF);
         lvl_v <= 15'($urandom);
         repeat (3) @(posedge core_clk_in);
         @(negedge core_clk_in);
         check("gate", {1'b0, first_req_out}, {1'b0, lvl_v & d[14:0]});
         check("enable", {1'b0, enable_out}, {1'b0, d[14:0]});
      end
      $display("enables done");
      acc = 7'h00;
      for (int i = 0; i < 7; i++) begin
         pulse(7'h01 << i);
         acc |= 7'h01 << i;
         rd(4'h0, {9'h000, acc});
      end
      check("pend", {9'h000, flag_pend_out}, 16'h007F);
      check("pend nocan", {9'h000, pend_nc}, 16'h0073);
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'h0000);
      wr(4'h0, 16'hFFFF);
      rd(4'h0, 16'h007F);
      $display("flags done");
      rd(4'h2, 16'h007F);
      wr(4'h3, 16'hFFC0);
      rd(4'h3, 16'h0040);
      pulse(7'h20);
      check("irq masked", {15'h0, irq_out}, 16'h0000);
      pulse(7'h40);
      check("irq", {15'h0, irq_out}, 16'h0001);
      rd(4'h2, 16'h0060);
      repeat (2) @(posedge core_clk_in);
      @(negedge core_clk_in);
      check("irq clear", {15'h0, irq_out}, 16'h0000);
      wr(4'h3, 16'h0008);
      pulse(7'h08);
      check("irq can", {15'h0, irq_out}, 16'h0001);
      check("irq nocan", {15'h0, irq_nc}, 16'h0000);
      rd(4'h2, 16'h0008);
      repeat (2) @(posedge core_clk_in);
      @(negedge core_clk_in);
      check("irq can clear", {15'h0, irq_out}, 16'h0000);
      $display("interrupts done");
      summarize();
   end
   initial begin
      #(3000 * 25);
      bad_count++;
      summarize();
   end
endmodule // ifb_top_test
`default_nettype wire
